/* File: common/slg_consts.svh */
// Constants for the start lock gating block
`ifndef SLG_CONSTS_SVH
`define SLG_CONSTS_SVH
`define SLG_OFF_LOCK 12'h000
`define SLG_OFF_STATUS 12'h004
`define SLG_OFF_CMD 12'h008
`define SLG_LOCK_RESET 1'b0
`define SLG_BIT_RUNNING 0
`define SLG_BIT_KEY 1
`define SLG_BIT_REJECT 2
`endif

/* File: common/slg_pkg.sv */
// Types for the start lock gating block
package slg_pkg;
	typedef struct packed {
		logic fwd;
		logic rev;
	} slg_start_t;
	typedef struct packed {
		logic fwd_term;
		logic rev_term;
		logic fwd_panel;
		logic rev_panel;
		logic fwd_unit;
		logic rev_unit;
	} slg_sources_t;
endpackage

/* File: core/slg_start_lock.sv */
// Start lock gating with APB register access
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`include "slg_consts.svh"
module slg_start_lock
	import slg_pkg::*;
#(
	parameter int CMD_W = 16
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire slg_sources_t start_in,
	input wire logic seq_run_key,
	input wire logic seq_running,
	input wire logic [CMD_W-1:0] seq_drive_command_word,
	input wire logic drive_running,
	output slg_start_t start_permit_q,
	output logic stop_req_q,
	output logic [CMD_W-1:0] seq_cmd_held_q
);
	slg_sources_t src_s1_q, src_s2_q;
	logic key_s1_q, key_s2_q, key_d2_q;
	logic sqr_s1_q, sqr_s2_q, sqr_d2_q;
	logic run_s1_q, run_s2_q;
	logic lock_select_q;
	logic reject_q;
	logic access;
	logic fwd_any, rev_any, allowed, key_fall, seq_fall;

	// Two-flop synchronisers; only the second stage is read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			src_s1_q <= '0;
			src_s2_q <= '0;
			key_s1_q <= 1'b0;
			key_s2_q <= 1'b0;
			sqr_s1_q <= 1'b0;
			sqr_s2_q <= 1'b0;
			run_s1_q <= 1'b0;
			run_s2_q <= 1'b0;
		end
		else
		begin
			src_s1_q <= start_in;
			src_s2_q <= src_s1_q;
			key_s1_q <= seq_run_key;
			key_s2_q <= key_s1_q;
			sqr_s1_q <= seq_running;
			sqr_s2_q <= sqr_s1_q;
			run_s1_q <= drive_running;
			run_s2_q <= run_s1_q;
		end
	end

	// Edge history for falling-edge detection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			key_d2_q <= 1'b0;
			sqr_d2_q <= 1'b0;
		end
		else
		begin
			key_d2_q <= key_s2_q;
			sqr_d2_q <= sqr_s2_q;
		end
	end

	// All start sources merge before one gate
	assign fwd_any = src_s2_q.fwd_term | src_s2_q.fwd_panel | src_s2_q.fwd_unit;
	assign rev_any = src_s2_q.rev_term | src_s2_q.rev_panel | src_s2_q.rev_unit;
	assign allowed = !lock_select_q || key_s2_q;
	assign key_fall = key_d2_q && !key_s2_q;
	assign seq_fall = sqr_d2_q && !sqr_s2_q;
	assign access = psel && penable;

	// Gated permits; with lock selected, key in STOP blocks both directions
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			start_permit_q <= '0;
		else
		begin
			start_permit_q.fwd <= fwd_any && allowed;
			start_permit_q.rev <= rev_any && allowed;
		end
	end

	// One-cycle stop request; ramp belongs downstream
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stop_req_q <= 1'b0;
		else
			stop_req_q <= lock_select_q && run_s2_q && (key_fall || seq_fall);
	end

	// Sequence command data frozen when sequence stops unlocked
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			seq_cmd_held_q <= '0;
		else if (sqr_s2_q)
			seq_cmd_held_q <= seq_drive_command_word;
		else if (lock_select_q)
			seq_cmd_held_q <= '0;
		// Otherwise hold last value so operation continues
	end

	// Lock-select write; refused while running regardless of write guard
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lock_select_q <= `SLG_LOCK_RESET;
			reject_q <= 1'b0;
		end
		else if (access && pwrite && paddr == `SLG_OFF_LOCK)
		begin
			// Uses the synced run flag as seen at the access edge itself
			if (run_s2_q || pwdata[31:1] != 31'h0)
				reject_q <= 1'b1;
			else
			begin
				lock_select_q <= pwdata[0];
				reject_q <= 1'b0;
			end
		end
	end

	// APB answer: zero wait, error on unmapped or refused write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel && !penable)
			begin
				unique case (paddr)
					`SLG_OFF_LOCK: prdata <= {31'h0, lock_select_q};
					`SLG_OFF_STATUS:
						prdata <= {29'h0, reject_q, key_s2_q, run_s2_q};
					`SLG_OFF_CMD: prdata <= 32'(seq_cmd_held_q);
					default: pslverr <= 1'b1;
				endcase
				if (pwrite && paddr == `SLG_OFF_LOCK && (run_s2_q || pwdata[31:1] != 31'h0))
					pslverr <= 1'b1;
				if (pwrite && paddr == `SLG_OFF_STATUS)
					pslverr <= 1'b1;
			end
		end
	end

	// Rule checks on the synchronised view of the inputs
	AST_LOCK_STAYS_WHEN_RUNNING: assert property (@(posedge pclk) disable iff (!presetn)
		run_s2_q |=> $stable(lock_select_q))
		else $error("lock select changed while running");
	AST_UNLOCKED_PASSES: assert property (@(posedge pclk) disable iff (!presetn)
		!lock_select_q && fwd_any |=> start_permit_q.fwd)
		else $error("forward start dropped while unlocked");
	AST_LOCKED_NEEDS_KEY: assert property (@(posedge pclk) disable iff (!presetn)
		lock_select_q && key_s2_q && rev_any |=> start_permit_q.rev)
		else $error("reverse start dropped in RUN");
	AST_STOP_KEY_BLOCKS: assert property (@(posedge pclk) disable iff (!presetn)
		lock_select_q && !key_s2_q |=> !start_permit_q.fwd && !start_permit_q.rev)
		else $error("start passed with key in STOP");
	sequence key_leaves_run;
		lock_select_q && run_s2_q && key_d2_q && !key_s2_q;
	endsequence
	AST_KEY_STOP_DECEL: assert property (@(posedge pclk) disable iff (!presetn)
		key_leaves_run |=> stop_req_q ##1 (!stop_req_q || $past(seq_fall)))
		else $error("no stop request on key leaving RUN");
	AST_SEQ_STOP_HALTS: assert property (@(posedge pclk) disable iff (!presetn)
		lock_select_q && run_s2_q && seq_fall |=> stop_req_q)
		else $error("no stop when sequence stopped");
	AST_UNLOCKED_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
		!lock_select_q && !sqr_s2_q |=> $stable(seq_cmd_held_q))
		else $error("command data changed after sequence stop");
	AST_NO_STOP_UNLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
		!lock_select_q |=> !stop_req_q)
		else $error("stop request while unlocked");
	AST_PANEL_GATED: assert property (@(posedge pclk) disable iff (!presetn)
		src_s2_q.fwd_panel && allowed |=> start_permit_q.fwd)
		else $error("panel start not honoured");
	AST_SELECT_BINARY: assert property (@(posedge pclk) disable iff (!presetn)
		access && pwrite && paddr == `SLG_OFF_LOCK && pwdata[31:1] != 31'h0 |=> $stable(lock_select_q))
		else $error("illegal lock select value accepted");
	AST_REFUSED_FLAGGED: assert property (@(posedge pclk) disable iff (!presetn)
		access && pwrite && paddr == `SLG_OFF_LOCK && run_s2_q |=> reject_q)
		else $error("refused lock write not flagged");

	// Bus timing promised to the master: one wait-free access
	AST_APB_READY_NEXT: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready)
		else $error("access cycle without ready");
	AST_APB_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held beyond one cycle");
	// Command data path while the sequence runs, and after a locked stop
	AST_HELD_TRACKS: assert property (@(posedge pclk) disable iff (!presetn)
		sqr_s2_q |=> seq_cmd_held_q == $past(seq_drive_command_word))
		else $error("command data not passed on");
	AST_LOCKED_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
		lock_select_q && !sqr_s2_q |=> seq_cmd_held_q == '0)
		else $error("command data kept after locked stop");
endmodule // slg_start_lock

/* File: test/slg_partner.sv */
// Sequence program model: run key, run state, command word
module slg_partner
(
	input wire logic pclk,
	input wire logic key_cmd,
	input wire logic run_cmd,
	input wire logic [15:0] word_cmd,
	output logic seq_run_key,
	output logic seq_running,
	output logic [15:0] seq_drive_command_word
);
	timeunit 1ns;
	timeprecision 1ns;
	// Outputs change only on the clock, like a scanned program
	always_ff @(posedge pclk)
	begin
		seq_run_key <= key_cmd;
		seq_running <= run_cmd;
		seq_drive_command_word <= word_cmd; // Held steady so late copies agree
	end
endmodule // slg_partner

/* File: test/slg_start_lock_tb.sv */
// Bench for the start lock gating block
module slg_start_lock_tb import slg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, key = 0, run = 0, drv = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, er, srk, srun, stop_req_q;
	logic [15:0] word = 0, sword, held, kept;
	slg_sources_t start_in = '0;
	slg_start_t permit;
	int bad_count = 0, compares = 0, n;
	slg_start_lock u_slg_start_lock (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .start_in(start_in), .seq_run_key(srk), .seq_running(srun),
		.seq_drive_command_word(sword), .drive_running(drv), .start_permit_q(permit),
		.stop_req_q(stop_req_q), .seq_cmd_held_q(held));
	slg_partner u_slg_partner (.pclk(pclk), .key_cmd(key), .run_cmd(run), .word_cmd(word),
		.seq_run_key(srk), .seq_running(srun), .seq_drive_command_word(sword));
	always #5 pclk = ~pclk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t %h %h", $time, got, exp);
		end
	endtask
	// Setup, then access held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	// Stop pulses seen in a fixed window
	task pulses();
		n = 0;
		repeat (8) @(posedge pclk) n += int'(stop_req_q === 1'b1);
	endtask
	function automatic logic [1:0] expp(logic lk, logic k, slg_sources_t s);
		return {s.fwd_term | s.fwd_panel | s.fwd_unit, s.rev_term | s.rev_panel | s.rev_unit} & {2{!lk | k}};
	endfunction
	task results();
		$display("compares %0d bad %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial
	begin
		repeat (5000) @(posedge pclk);
		bad_count++;
		results();
	end
	initial
	begin
		void'($urandom(32'h37444690));
		repeat (5) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, 12'h000, 0);
		chk(rd, 0);
		apb(1, 12'h000, 32'h2);
		chk(32'(er), 1);
		apb(0, 12'h00c, 0);
		chk(32'(er), 1);
		$display("register test done");
		for (int i = 0; i < 24; i++)
		begin
			apb(1, 12'h000, 32'(i[1]));
			key <= i[0];
			start_in <= 6'($urandom);
			repeat (6) @(posedge pclk);
			chk(32'(permit), 32'(expp(i[1], i[0], start_in)));
		end
		$display("gating test done");
		apb(1, 12'h000, 1);
		key <= 1;
		drv <= 1;
		run <= 1;
		word <= 16'($urandom);
		repeat (6) @(posedge pclk);
		chk(32'(held), 32'(word));
		key <= 0;
		pulses();
		chk(32'(n), 1);
		key <= 1;
		run <= 0;
		pulses();
		chk(32'(n), 1);
		chk(32'(held), 0);
		apb(1, 12'h000, 0);
		chk(32'(er), 1);
		apb(0, 12'h000, 0);
		chk(rd, 1);
		apb(0, 12'h004, 0);
		chk(rd, 32'h7);
		apb(1, 12'h004, 0);
		chk(32'(er), 1);
		drv <= 0;
		// Drive stop must pass the synchroniser before the write
		repeat (3) @(posedge pclk);
		apb(1, 12'h000, 0);
		chk(32'(er), 0);
		apb(0, 12'h004, 0);
		chk(rd, 32'h2);
		drv <= 1;
		run <= 1;
		repeat (6) @(posedge pclk);
		run <= 0;
		pulses();
		chk(32'(n), 0);
		// New word after the stop must not reach the held copy
		kept = word;
		word <= ~word;
		repeat (4) @(posedge pclk);
		chk(32'(held), 32'(kept));
		apb(0, 12'h008, 0);
		chk(rd, 32'(kept));
		$display("stop test done");
		results();
	end
endmodule // slg_start_lock_tb
